// *** include/usr_regs.svh ***
// constants for the 4-bit universal shift register
`ifndef USR_REGS_SVH
`define USR_REGS_SVH

`define USR_WIDTH 4
`define USR_SYNC_STAGES 3
`define USR_RESET_VALUE 4'h0
`define USR_SEL_HOLD 2'h0
`define USR_SEL_RIGHT 2'h1
`define USR_SEL_LEFT 2'h2
`define USR_SEL_LOAD 2'h3

`endif

// *** include/usr_pkg.sv ***
// types for the 4-bit universal shift register
`default_nettype none

package usr_pkg;
    typedef enum {USR_HOLD, USR_SHIFT_RIGHT, USR_SHIFT_LEFT, USR_LOAD} usr_mode_type;
endpackage

`default_nettype wire

// *** logic/usr_shift_reg.sv ***
// 4-bit bidirectional universal shift register with pin synchronisers
`include "usr_regs.svh"
`default_nettype none

module usr_shift_reg #(
    parameter int WIDTH = `USR_WIDTH
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clear_n,
    input wire logic i_shift_clk,
    input wire logic i_mode_sel_0,
    input wire logic i_mode_sel_1,
    input wire logic i_right_serial_in,
    input wire logic i_left_serial_in,
    input wire logic [WIDTH-1:0] i_parallel_in,
    output logic [WIDTH-1:0] o_reg_out
);
    localparam int PW = WIDTH + 5;
    // reset pattern sized to the register, whatever WIDTH is
    localparam logic [WIDTH-1:0] RESET_VALUE = WIDTH'(`USR_RESET_VALUE);

    // decode the two select pins into a mode
    function automatic usr_pkg::usr_mode_type decode_mode(input logic [1:0] sel);
        case (sel)
            `USR_SEL_HOLD: decode_mode = usr_pkg::USR_HOLD;
            `USR_SEL_RIGHT: decode_mode = usr_pkg::USR_SHIFT_RIGHT;
            `USR_SEL_LEFT: decode_mode = usr_pkg::USR_SHIFT_LEFT;
            `USR_SEL_LOAD: decode_mode = usr_pkg::USR_LOAD;
            default: decode_mode = usr_pkg::USR_LOAD;
        endcase
    endfunction

    // clear acts asynchronously with the chip reset; release goes through two flops
    logic rst_async_n;
    logic rst_meta;
    logic rst_sync;
    logic next_rst_meta;
    logic next_rst_sync;
    assign rst_async_n = i_rst_n & i_clear_n;
    // a ripple of ones; release lands on a clock edge, never between two
    always_comb begin
        next_rst_meta = 1'b1;
        next_rst_sync = rst_meta;
    end
    always_ff @(posedge i_clock or negedge rst_async_n) begin
        if (!rst_async_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= next_rst_meta;
            rst_sync <= next_rst_sync;
        end
    end

    // pins cross three flops; all share one delay so data lines up with the clock pin
    // trade-off: three cycles of latency, but no skew between mode, data and clock
    logic [PW-1:0] pins;
    logic [PW-1:0] sync_1;
    logic [PW-1:0] sync_2;
    logic [PW-1:0] sync_3;
    logic [PW-1:0] next_sync_1;
    logic [PW-1:0] next_sync_2;
    logic [PW-1:0] next_sync_3;
    assign pins = {i_shift_clk, i_mode_sel_1, i_mode_sel_0, i_right_serial_in,
                   i_left_serial_in, i_parallel_in};
    always_comb begin
        next_sync_1 = pins;
        next_sync_2 = sync_1;
        next_sync_3 = sync_2;
    end
    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            sync_1 <= '0;
            sync_2 <= '0;
            sync_3 <= '0;
        end else begin
            sync_1 <= next_sync_1;
            sync_2 <= next_sync_2;
            sync_3 <= next_sync_3;
        end
    end

    // fields of the settled third stage, plus the stage-two copy of the clock pin
    logic clk_2;
    logic clk_3;
    logic [1:0] sel_s;
    logic right_s;
    logic left_s;
    logic [WIDTH-1:0] par_s;
    assign clk_2 = sync_2[PW-1];
    assign clk_3 = sync_3[PW-1];
    assign sel_s = sync_3[PW-2:PW-3];
    assign right_s = sync_3[WIDTH+1];
    assign left_s = sync_3[WIDTH];
    assign par_s = sync_3[WIDTH-1:0];

    // accepted clock level moves only when stages two and three agree;
    // a shift clock phase shorter than about two cycles of i_clock is missed,
    // the price of filtering glitches on a pin with no clock relation;
    // mode and data come from stage three, like the accepted rise, so they need only settle by the edge that first sees the clock high
    logic clk_level;
    logic next_clk_level;
    logic clk_rise;
    usr_pkg::usr_mode_type mode;
    assign clk_rise = clk_2 & clk_3 & ~clk_level;
    assign mode = decode_mode(sel_s);
    always_comb begin
        next_clk_level = clk_level;
        if (clk_2 == clk_3) begin
            next_clk_level = clk_3;
        end
    end

    // the register itself; falling edges and steady levels leave it alone
    logic [WIDTH-1:0] next_reg_out;
    always_comb begin
        next_reg_out = o_reg_out;
        if (!rst_sync) begin
            // synced release holds zero until the first accepted rise
            next_reg_out = RESET_VALUE;
        end else if (clk_rise) begin
            case (mode)
                usr_pkg::USR_HOLD: next_reg_out = o_reg_out;
                usr_pkg::USR_SHIFT_RIGHT: next_reg_out = {o_reg_out[WIDTH-2:0], right_s};
                usr_pkg::USR_SHIFT_LEFT: next_reg_out = {left_s, o_reg_out[WIDTH-1:1]};
                usr_pkg::USR_LOAD: next_reg_out = par_s;
                default: next_reg_out = o_reg_out;
            endcase
        end
    end

    // async clear, not the synced copy, so outputs drop at once
    always_ff @(posedge i_clock or negedge rst_async_n) begin
        if (!rst_async_n) begin
            o_reg_out <= RESET_VALUE;
        end else begin
            o_reg_out <= next_reg_out;
        end
    end

    // accepted level of the shift clock pin
    always_ff @(posedge i_clock or negedge rst_sync) begin
        if (!rst_sync) begin
            clk_level <= 1'b0;
        end else begin
            clk_level <= next_clk_level;
        end
    end

    // checks; mode checks look one edge after an accepted rise
    load_update_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_LOAD |=> o_reg_out == $past(par_s))
        else $error("parallel load did not copy inputs");
    hold_keeps_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_HOLD |=> $stable(o_reg_out))
        else $error("hold mode changed the register");
    shift_right_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_RIGHT |=>
        o_reg_out[WIDTH-1:1] == $past(o_reg_out[WIDTH-2:0]))
        else $error("shift right moved bits wrongly");
    shift_left_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_LEFT |=>
        o_reg_out[WIDTH-2:0] == $past(o_reg_out[WIDTH-1:1]))
        else $error("shift left moved bits wrongly");

    // edge checks: only an accepted rise moves the register
    no_edge_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        !clk_rise ##1 rst_sync |-> $stable(o_reg_out))
        else $error("register changed without a clock rise");

    // clear checks stay armed while clear holds the internal reset low; only the chip reset i_rst_n disables them
    clear_low_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_clear_n |-> o_reg_out == `USR_RESET_VALUE)
        else $error("outputs not low during clear");
    resume_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        $rose(rst_sync) |-> o_reg_out == `USR_RESET_VALUE)
        else $error("outputs moved before clear release settled");

    // serial inputs must not leak into the other modes
    load_serial_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_LOAD |=>
        o_reg_out[0] == $past(par_s[0]) && o_reg_out[WIDTH-1] == $past(par_s[WIDTH-1]))
        else $error("serial input leaked into parallel load");
    shift_serial_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_LEFT |=> o_reg_out[WIDTH-1] == $past(left_s))
        else $error("left shift took the wrong serial input");
    right_serial_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_RIGHT |=> o_reg_out[0] == $past(right_s))
        else $error("right shift took the wrong serial input");

    // guards around the clock fall and the clear window
    fall_ignored_a: assert property (@(posedge i_clock) disable iff (!rst_sync)
        clk_level && !clk_2 && !clk_3 |=> $stable(o_reg_out))
        else $error("register changed on a shift clock fall");
    clear_stays_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_clear_n |=> o_reg_out == `USR_RESET_VALUE)
        else $error("outputs left low too early after clear");
    clear_flush_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !i_clear_n |-> !rst_sync && !clk_level)
        else $error("stale clock level survived a clear");

    // scenario covers
    load_seen_c: cover property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_LOAD);
    right_seen_c: cover property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_RIGHT ##[1:50] clk_rise);
    left_seen_c: cover property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_SHIFT_LEFT);
    clear_seen_c: cover property (@(posedge i_clock) disable iff (!i_rst_n)
        o_reg_out != `USR_RESET_VALUE ##1 !i_clear_n);
    hold_seen_c: cover property (@(posedge i_clock) disable iff (!rst_sync)
        clk_rise && mode == usr_pkg::USR_HOLD);
endmodule

`default_nettype wire

// *** sim/usr_pin_driver.sv ***
// pin-level model of the logic that drives the shift register
`default_nettype none

module usr_pin_driver (
    input wire logic i_clock,
    output logic o_clear_n,
    output logic o_shift_clk,
    output logic [1:0] o_sel,
    output logic o_right,
    output logic o_left,
    output logic [3:0] o_par
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle pins; clear stays inactive for normal work
    initial begin
        o_clear_n = 1'b1;
        o_shift_clk = 1'b0;
        o_sel = 2'h0;
        o_right = 1'b0;
        o_left = 1'b0;
        o_par = 4'h0;
    end

    // one shift clock pulse: setup 3, high 4, low 5 cycles
    task automatic op(input logic [1:0] s, input logic r, input logic l, input logic [3:0] d);
        @(negedge i_clock);
        o_sel = s;
        o_right = r;
        o_left = l;
        o_par = d;
        repeat (3) @(negedge i_clock);
        o_shift_clk = 1'b1;
        repeat (4) @(negedge i_clock);
        // scramble inputs before the fall so a falling edge acting would show
        o_right = ~r;
        o_left = ~l;
        o_par = ~d;
        o_shift_clk = 1'b0;
        repeat (5) @(negedge i_clock);
    endtask

    // clear pin level, changed at a falling edge
    task automatic clr(input logic v);
        @(negedge i_clock);
        o_clear_n = v;
    endtask
endmodule

`default_nettype wire

// *** sim/universal_shift_register_4bit_test.sv ***
// self-checking bench for the 4-bit universal shift register
`default_nettype none

module universal_shift_register_4bit_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic clear_n, shift_clk, right, left;
    logic [1:0] sel;
    logic [3:0] par, q;
    int n_fail = 0;
    int compares = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    usr_pin_driver i_usr_pin_driver (.i_clock(clock), .o_clear_n(clear_n),
        .o_shift_clk(shift_clk), .o_sel(sel), .o_right(right), .o_left(left), .o_par(par));

    usr_shift_reg i_usr_shift_reg (.i_clock(clock), .i_rst_n(rst_n), .i_clear_n(clear_n),
        .i_shift_clk(shift_clk), .i_mode_sel_0(sel[0]), .i_mode_sel_1(sel[1]),
        .i_right_serial_in(right), .i_left_serial_in(left), .i_parallel_in(par),
        .o_reg_out(q));

    // compare stored bits against expectation
    task automatic check(input logic [3:0] exp);
        compares++;
        if (q !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, q, exp);
            n_fail++;
        end
    endtask

    task automatic t_load();
        i_usr_pin_driver.op(2'h3, 1'b1, 1'b1, 4'hA);
        check(4'hA);
    endtask

    task automatic t_hold();
        i_usr_pin_driver.op(2'h0, 1'b1, 1'b1, 4'h5);
        check(4'hA);
    endtask

    task automatic t_shifts();
        i_usr_pin_driver.op(2'h1, 1'b1, 1'b0, 4'hF);
        check(4'h5);
        i_usr_pin_driver.op(2'h2, 1'b0, 1'b1, 4'h0);
        check(4'hA);
    endtask

    // clear acts without a clock; output stays low until the next rise
    task automatic t_clear();
        i_usr_pin_driver.clr(1'b0);
        #1;
        check(4'h0);
        repeat (2) @(negedge clock);
        i_usr_pin_driver.clr(1'b1);
        repeat (3) @(negedge clock);
        check(4'h0);
        i_usr_pin_driver.op(2'h3, 1'b0, 1'b0, 4'h6);
        check(4'h6);
    endtask

    task automatic print_verdict();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // reset 10 cycles, then the scenarios in turn
    initial begin
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        t_load();
        t_hold();
        t_shifts();
        t_clear();
        print_verdict();
    end
endmodule

`default_nettype wire
